/* File: core/bte_params.svh */
// constants for the bus trace state encoder: offsets, field positions, codes
`ifndef BTE_PARAMS_SVH
`define BTE_PARAMS_SVH

// register port map, byte addresses on an 8-bit address
`define BTE_REG_CTRL        8'h00
`define BTE_REG_STATUS      8'h04
`define BTE_CTRL_ENABLE     0
`define BTE_CTRL_VARIANT2   1
`define BTE_CTRL_RESET      2'h1

// memory-region attribute field positions
`define BTE_MM_EMUL         6
`define BTE_MM_ROM          5
`define BTE_MM_GUARD        4
`define BTE_MM_LOWTGT       3
`define BTE_MM_FIXED        3'h1

// status field positions
`define BTE_ST_CLASS_HI     25
`define BTE_ST_CLASS_LO     23
`define BTE_ST_SOURCE       22
`define BTE_ST_BRKPT        21
`define BTE_ST_SUPER        20
`define BTE_ST_PRERET       19
`define BTE_ST_RETURN       18
`define BTE_ST_CALL         17
`define BTE_ST_BRANCH       16
`define BTE_ST_INSTR        15
`define BTE_ST_BADAC_N      14
`define BTE_ST_VALID        13
`define BTE_ST_HOLD         10
`define BTE_ST_QUAL         9
`define BTE_ST_IRQ_LO       4
`define BTE_ST_IRQ_HI       7
`define BTE_ST_DIR          3
`define BTE_ST_LOCK_N       2
`define BTE_ST_CACHE        1

// three-bit class codes in status bits 25:23
`define BTE_CLASS_BUS       3'h1
`define BTE_CLASS_FLOW      3'h4
`define BTE_CLASS_BGND      3'h2

// counter limits
`define BTE_WAIT_MAX        4'hF
`define BTE_BURST_MAX       3'h7

`endif

/* File: core/bte_pkg.sv */
// types shared by the bus trace state encoder modules
`default_nettype none
package bte_pkg;

  // cause of the captured state
  typedef enum logic [1:0] {
    BTE_FOREGROUND,
    BTE_BACKGROUND,
    BTE_FLOW
  } bte_class_t;

  // execution-flow message kinds
  typedef enum logic [2:0] {
    BTE_K_INSTR,
    BTE_K_BRANCH,
    BTE_K_CALL,
    BTE_K_RETURN,
    BTE_K_PRERET,
    BTE_K_SUPER,
    BTE_K_BRKPT
  } bte_kind_t;

  // counter module state
  typedef struct packed {
    logic [3:0] wait_cnt;
    logic [2:0] burst_pos;
  } bte_cnt_state_t;

  // encoder state; every top output is one field here
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic [3:0]  wait_cnt;
    logic [2:0]  burst_pos;
    logic [1:0]  size;
    logic [1:0]  bstlen;
    logic [7:0]  memmap;
    logic [30:0] status;
    logic        foreground_cycle_flag;
    logic        background_cycle_flag;
    logic        flow_message_flag;
    logic        valid;
    logic        enable;
    logic        variant2;
    logic [3:0]  irq_seen;
    logic        hold_seen;
    logic [15:0] state_count;
    logic [31:0] rd_data;
  } bte_state_t;

endpackage
`default_nettype wire

/* File: core/bte_cnt_if.sv */
// wait-state and burst-position counter hookup
`default_nettype none
interface bte_cnt_if;
  logic       wait_tick;
  logic       data_done;
  logic       burst_start;
  logic       burst_data;
  logic [3:0] wait_count;
  logic [2:0] burst_pos;

  modport ctl (output wait_tick, output data_done, output burst_start,
               output burst_data, input wait_count, input burst_pos);
  modport cnt (input wait_tick, input data_done, input burst_start,
               input burst_data, output wait_count, output burst_pos);
endinterface
`default_nettype wire

/* File: core/bte_cycle_counter.sv */
// counts wait states per data cycle and the data position within a burst
`include "bte_params.svh"
`default_nettype none
module bte_cycle_counter
  import bte_pkg::*;
(
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RESET_N,
  // encoder side
  bte_cnt_if.cnt    cif
);

  bte_cnt_state_t st;
  bte_cnt_state_t next_st;

  // wait count restarts at each completion; completion cycle is not a wait
  always_comb begin
    next_st = st;
    if (cif.data_done) begin
      next_st.wait_cnt = 4'h0;
    end else if (cif.wait_tick && st.wait_cnt != `BTE_WAIT_MAX) begin
      next_st.wait_cnt = st.wait_cnt + 4'h1; // saturates at 15 [RULE20]
    end
    // position advances after each burst data cycle, held at 7 [RULE22]
    if (cif.burst_start) begin
      next_st.burst_pos = 3'h0;
    end else if (cif.data_done && cif.burst_data && st.burst_pos != `BTE_BURST_MAX) begin
      next_st.burst_pos = st.burst_pos + 3'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cif.wait_count = st.wait_cnt;
  assign cif.burst_pos  = st.burst_pos;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_WAIT_CLEAR: assert property (cif.data_done |=> cif.wait_count == 4'h0) // [RULE20]
    else $error("wait count not restarted after data cycle");
  AST_BURST_START: assert property (cif.burst_start |=> cif.burst_pos == 3'h0) // [RULE22]
    else $error("burst position not zero after burst start");

endmodule
`default_nettype wire

/* File: core/bte_encoder.sv */
// bus trace state encoder: builds one trace word per captured processor state
//
// Notes on behaviour
// (RULE1) size code: bytes minus one, 0h..3h
// (RULE2) burst code: words minus one, 0h..3h
// (RULE3) target 00xx x001, emulation 01xx x001
// (RULE4) rom bit set for rom, clear ram
// (RULE5) guarded access encodes as 0001 x001
// (RULE6) valid bit set when address/data valid
// (RULE7) direction bit: 0 read, 1 write
// (RULE8) class code bus 001, flow 100, background 010
// (RULE9) flow source address 1, destination 0
// (RULE10) one-hot message kind bits, flow only
// (RULE11) locked bus access drives lock bit low
// (RULE12) cacheable bus access sets cache bit
// (RULE13) bad bus access drives bad bit low
// (RULE14) sticky bit per interrupt pin seen
// (RULE15) sticky bus-hold bit, any class
// (RULE16) trace address: lowest byte of item
// (RULE17) flow messages carry word address
// (RULE18) sixteen data bits on lines 47:32
// (RULE19) flow data lines carry no content
// (RULE20) wait count 0..15 on lines 51:48
// (RULE21) exactly one class flag per state
// (RULE22) second variant burst position 0..7
// (RULE23) whole word registered together per state
`include "bte_params.svh"
`default_nettype none
module bte_encoder
  import bte_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  // captured processor state
  input  wire logic        BUS_STATE_VALID,
  input  wire bte_class_t  BUS_CLASS,
  input  wire logic        BUS_AD_VALID,
  input  wire logic [31:0] BUS_ADDR,
  input  wire logic [15:0] BUS_DATA,
  input  wire logic [3:0]  BUS_BYTE_EN,
  input  wire logic [2:0]  BUS_BURST_WORDS,
  input  wire logic        BUS_WRITE,
  input  wire logic        BUS_LOCK_N,
  input  wire logic        BUS_CACHEABLE,
  input  wire logic        BUS_BAD_ACCESS,
  input  wire logic        BUS_EMUL_MEM,
  input  wire logic        BUS_ROM,
  input  wire logic        BUS_GUARDED,
  input  wire logic        BUS_LOW_TARGET,
  input  wire bte_kind_t   BUS_FLOW_KIND,
  input  wire logic        BUS_FLOW_SOURCE,
  // per-clock processor activity
  input  wire logic        BUS_WAIT,
  input  wire logic        BUS_BURST_START,
  input  wire logic        BUS_IN_BURST,
  input  wire logic [3:0]  BUS_IRQ,
  input  wire logic        BUS_HOLD,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WR_DATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [31:0] REG_RD_DATA,
  // trace word to the analyzer
  output var  logic        TRACE_VALID,
  output var  logic [31:0] TRACE_ADDR,
  output var  logic [15:0] TRACE_DATA,
  output var  logic [3:0]  TRACE_WAIT,
  output var  logic [2:0]  TRACE_BURST_POS,
  output var  logic [1:0]  TRACE_SIZE,
  output var  logic [1:0]  TRACE_BSTLEN,
  output var  logic [7:0]  TRACE_MEMMAP,
  output var  logic [30:0] TRACE_STATUS,
  output var  logic        FOREGROUND_CYCLE_FLAG,
  output var  logic        BACKGROUND_CYCLE_FLAG,
  output var  logic        FLOW_MESSAGE_FLAG
);

  bte_state_t st;
  bte_state_t next_st;

  bte_cnt_if cif ();

  // byte enables to size code; an empty mask reads as one byte
  function automatic logic [1:0] size_code(input logic [3:0] be);
    logic [2:0] n;
    n = 3'({2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]});
    return (n == 3'h0) ? 2'h0 : 2'(n - 3'h1);
  endfunction

  // word count to burst code; counts above four clip to four words, zero codes as one word
  function automatic logic [1:0] burst_code(input logic [2:0] words);
    if (words == 3'h0) begin
      return 2'h0;
    end else if (words > 3'h4) begin
      return 2'h3;
    end
    return 2'(words - 3'h1);
  endfunction

  // message kind to its one-hot bit, ordered instr..brkpt
  function automatic logic [6:0] kind_onehot(input bte_kind_t kind);
    logic [6:0] oh;
    oh = 7'h00;
    case (kind)
      BTE_K_INSTR:  oh = 7'h01;
      BTE_K_BRANCH: oh = 7'h02;
      BTE_K_CALL:   oh = 7'h04;
      BTE_K_RETURN: oh = 7'h08;
      BTE_K_PRERET: oh = 7'h10;
      BTE_K_SUPER:  oh = 7'h20;
      BTE_K_BRKPT:  oh = 7'h40;
      default:      oh = 7'h00;
    endcase
    return oh;
  endfunction

  logic       capture;
  logic       is_fg;
  logic       is_bg;
  logic       is_flow;
  logic [6:0] kind_bits;

  // one decode of the class feeds every flag, so they cannot overlap
  always_comb begin
    capture   = BUS_STATE_VALID && st.enable;
    is_fg     = 1'b0;
    is_bg     = 1'b0;
    is_flow   = 1'b0;
    case (BUS_CLASS)
      BTE_BACKGROUND: is_bg   = 1'b1; // [RULE21]
      BTE_FLOW:       is_flow = 1'b1; // [RULE21]
      default:        is_fg   = 1'b1; // [RULE21]
    endcase
    kind_bits = kind_onehot(BUS_FLOW_KIND);
  end

  // counter hookup: every captured data state closes a data cycle
  assign cif.wait_tick   = BUS_WAIT;
  assign cif.data_done   = capture && !is_flow;
  assign cif.burst_start = BUS_BURST_START;
  assign cif.burst_data  = BUS_IN_BURST;

  bte_cycle_counter u_counter (
    .MCLK    (MCLK),
    .RESET_N (RESET_N),
    .cif     (cif)
  );

  // next state: trace word, sticky activity, register port
  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;

    // sticky pin activity; a pin active in the capture cycle is carried
    // into this word and also kept, so no pulse is ever dropped
    next_st.irq_seen  = st.irq_seen | BUS_IRQ; // [RULE14]
    next_st.hold_seen = st.hold_seen | BUS_HOLD; // [RULE15]

    if (capture) begin
      // all fields load in the same edge from the same state [RULE23]
      next_st.valid                 = 1'b1;
      next_st.foreground_cycle_flag = is_fg; // [RULE21]
      next_st.background_cycle_flag = is_bg; // [RULE21]
      next_st.flow_message_flag     = is_flow; // [RULE21]
      next_st.state_count           = st.state_count + 16'h0001;

      // flow messages hold a word address, data accesses a byte address
      next_st.addr = is_flow ? {BUS_ADDR[31:2], 2'b00} : BUS_ADDR; // [RULE16] [RULE17]
      next_st.data = is_flow ? 16'h0000 : BUS_DATA; // [RULE18] [RULE19]
      next_st.size   = size_code(BUS_BYTE_EN); // [RULE1]
      next_st.bstlen = burst_code(BUS_BURST_WORDS); // [RULE2]
      next_st.wait_cnt = is_flow ? 4'h0 : cif.wait_count; // [RULE20]
      // burst position only on the second variant, and only inside a burst
      next_st.burst_pos = (st.variant2 && BUS_IN_BURST && !is_flow) ?
                          cif.burst_pos : 3'h0; // [RULE22]

      // region attributes; guarded forces the emulation and rom bits clear
      next_st.memmap                 = 8'h00;
      next_st.memmap[2:0]            = `BTE_MM_FIXED; // [RULE3]
      next_st.memmap[`BTE_MM_EMUL]   = BUS_EMUL_MEM && !BUS_GUARDED; // [RULE3]
      next_st.memmap[`BTE_MM_ROM]    = BUS_ROM && !BUS_GUARDED; // [RULE4]
      next_st.memmap[`BTE_MM_GUARD]  = BUS_GUARDED; // [RULE5]
      next_st.memmap[`BTE_MM_LOWTGT] = BUS_LOW_TARGET;

      // status field; unused bits read as zero
      next_st.status = 31'h0000_0000;
      next_st.status[`BTE_ST_VALID] = BUS_AD_VALID; // [RULE6]
      next_st.status[`BTE_ST_QUAL]  = !is_bg; // [RULE8]
      if (is_flow) begin
        next_st.status[`BTE_ST_CLASS_HI:`BTE_ST_CLASS_LO] = `BTE_CLASS_FLOW; // [RULE8]
        next_st.status[`BTE_ST_SOURCE] = BUS_FLOW_SOURCE; // [RULE9]
        next_st.status[`BTE_ST_BRKPT:`BTE_ST_INSTR] = kind_bits; // [RULE10]
      end else if (is_bg) begin
        next_st.status[`BTE_ST_CLASS_HI:`BTE_ST_CLASS_LO] = `BTE_CLASS_BGND; // [RULE8]
        next_st.status[`BTE_ST_DIR] = BUS_WRITE; // [RULE7]
      end else begin
        next_st.status[`BTE_ST_CLASS_HI:`BTE_ST_CLASS_LO] = `BTE_CLASS_BUS; // [RULE8]
        next_st.status[`BTE_ST_DIR] = BUS_WRITE; // [RULE7]
      end
      // lock and bad-access are active low: idle high outside bus cycles
      next_st.status[`BTE_ST_LOCK_N]  = !(is_fg && !BUS_LOCK_N) ; // [RULE11]
      next_st.status[`BTE_ST_CACHE]   = is_fg && BUS_CACHEABLE; // [RULE12]
      next_st.status[`BTE_ST_BADAC_N] = !(is_fg && BUS_BAD_ACCESS); // [RULE13]
      next_st.status[`BTE_ST_IRQ_HI:`BTE_ST_IRQ_LO] = st.irq_seen | BUS_IRQ; // [RULE14]
      next_st.status[`BTE_ST_HOLD] = st.hold_seen | BUS_HOLD; // [RULE15]

      // activity reported; restart from this cycle's pins (set wins)
      next_st.irq_seen  = BUS_IRQ; // [RULE14]
      next_st.hold_seen = BUS_HOLD; // [RULE15]
    end

    // register writes steer capture and the burst-position variant
    if (REG_WR && REG_ADDR == `BTE_REG_CTRL) begin
      next_st.enable   = REG_WR_DATA[`BTE_CTRL_ENABLE];
      next_st.variant2 = REG_WR_DATA[`BTE_CTRL_VARIANT2];
    end

    // read data stand for exactly one cycle; unmapped reads return zero
    next_st.rd_data = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `BTE_REG_CTRL:   next_st.rd_data = {30'h0000_0000, st.variant2, st.enable};
        `BTE_REG_STATUS: next_st.rd_data = {11'h000, st.hold_seen, st.irq_seen,
                                            st.state_count};
        default:         next_st.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // one register stage holds the whole encoder state
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st          <= '0;
      st.enable   <= 1'b1;
      st.variant2 <= 1'b0;
      st.status   <= 31'h0000_4004;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign REG_RD_DATA           = st.rd_data;
  assign TRACE_VALID           = st.valid;
  assign TRACE_ADDR            = st.addr;
  assign TRACE_DATA            = st.data;
  assign TRACE_WAIT            = st.wait_cnt;
  assign TRACE_BURST_POS       = st.burst_pos;
  assign TRACE_SIZE            = st.size;
  assign TRACE_BSTLEN          = st.bstlen;
  assign TRACE_MEMMAP          = st.memmap;
  assign TRACE_STATUS          = st.status;
  assign FOREGROUND_CYCLE_FLAG = st.foreground_cycle_flag;
  assign BACKGROUND_CYCLE_FLAG = st.background_cycle_flag;
  assign FLOW_MESSAGE_FLAG     = st.flow_message_flag;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_SIZE_WORD: assert property ( // [RULE1]
    (capture && BUS_BYTE_EN == 4'hF) |=> TRACE_SIZE == 2'h3)
    else $error("four-byte access not coded as 3h");
  AST_BURST_LEN: assert property ( // [RULE2]
    (capture && BUS_BURST_WORDS == 3'h2) |=> TRACE_BSTLEN == 2'h1)
    else $error("two-word burst not coded as 1h");
  AST_GUARDED: assert property ( // [RULE5]
    (capture && BUS_GUARDED) |=> TRACE_MEMMAP[7:4] == 4'h1 && TRACE_MEMMAP[2:0] == 3'h1)
    else $error("guarded access pattern wrong");
  AST_ROM_EMUL: assert property ( // [RULE4]
    (capture && !BUS_GUARDED) |=> TRACE_MEMMAP[6:5] == $past({BUS_EMUL_MEM, BUS_ROM}))
    else $error("region bits do not follow access");
  AST_CLASS_ONEHOT: assert property ( // [RULE21]
    TRACE_VALID |-> $onehot({FOREGROUND_CYCLE_FLAG, BACKGROUND_CYCLE_FLAG,
                             FLOW_MESSAGE_FLAG}))
    else $error("class flags not exclusive");
  AST_BGND_CODE: assert property ( // [RULE8]
    (TRACE_VALID && BACKGROUND_CYCLE_FLAG) |->
      TRACE_STATUS[25:23] == 3'h2 && !TRACE_STATUS[9])
    else $error("background class code wrong");
  AST_FLOW_KIND: assert property ( // [RULE10]
    (TRACE_VALID && !FLOW_MESSAGE_FLAG) |-> TRACE_STATUS[21:15] == 7'h00)
    else $error("message kind bits outside flow message");
  AST_LOCK: assert property ( // [RULE11]
    (capture && is_fg && !BUS_LOCK_N) |=> !TRACE_STATUS[2])
    else $error("locked cycle not reported low");
  AST_DIR: assert property ( // [RULE7]
    (capture && !is_flow) |=> TRACE_STATUS[3] == $past(BUS_WRITE))
    else $error("direction bit wrong");
  AST_IRQ_STICKY: assert property ( // [RULE14]
    (BUS_IRQ[2] && !capture) ##1 !capture ##1 capture |=> TRACE_STATUS[6])
    else $error("interrupt pin activity lost");
  AST_ADDR: assert property ( // [RULE16]
    (capture && is_fg) |=> TRACE_ADDR == $past(BUS_ADDR) && TRACE_DATA == $past(BUS_DATA))
    else $error("address or data not captured");
  AST_BURST_ZERO: assert property ( // [RULE22]
    (capture && !BUS_IN_BURST) |=> TRACE_BURST_POS == 3'h0)
    else $error("non-burst cycle shows nonzero position");
  // further per-field checks
  AST_NO_CAPTURE: assert property ( // [RULE23]
    !capture |=> !TRACE_VALID)
    else $error("trace word without capture");
  AST_SIZE_BYTE: assert property ( // [RULE1]
    (capture && BUS_BYTE_EN == 4'h1) |=> TRACE_SIZE == 2'h0)
    else $error("one-byte access not coded as 0h");
  AST_REGION_FIXED: assert property ( // [RULE3]
    capture |=> !TRACE_MEMMAP[7] && TRACE_MEMMAP[2:0] == 3'h1)
    else $error("region pattern wrong");
  AST_AD_VALID: assert property ( // [RULE6]
    capture |=> TRACE_STATUS[13] == $past(BUS_AD_VALID))
    else $error("valid bit wrong");
  AST_BUS_CODE: assert property ( // [RULE8]
    (TRACE_VALID && FOREGROUND_CYCLE_FLAG) |-> TRACE_STATUS[25:23] == 3'h1 && TRACE_STATUS[9])
    else $error("bus class code wrong");
  AST_FLOW_CODE: assert property ( // [RULE8]
    (TRACE_VALID && FLOW_MESSAGE_FLAG) |-> TRACE_STATUS[25:23] == 3'h4)
    else $error("flow class code wrong");
  AST_SOURCE: assert property ( // [RULE9]
    (capture && is_flow) |=> TRACE_STATUS[22] == $past(BUS_FLOW_SOURCE))
    else $error("source bit wrong");
  AST_KIND_ONEHOT: assert property ( // [RULE10]
    (TRACE_VALID && FLOW_MESSAGE_FLAG) |-> $onehot(TRACE_STATUS[21:15]))
    else $error("message kind not one-hot");
  AST_CACHE: assert property ( // [RULE12]
    (capture && is_fg) |=> TRACE_STATUS[1] == $past(BUS_CACHEABLE))
    else $error("cache bit wrong");
  AST_BAD: assert property ( // [RULE13]
    (capture && is_fg) |=> TRACE_STATUS[14] != $past(BUS_BAD_ACCESS))
    else $error("bad-access bit wrong");
  AST_HOLD_STICKY: assert property ( // [RULE15]
    (BUS_HOLD && !capture) ##1 !capture ##1 capture |=> TRACE_STATUS[10])
    else $error("bus hold activity lost");
  AST_FLOW_WORD: assert property ( // [RULE17] [RULE19]
    (capture && is_flow) |=> TRACE_ADDR[1:0] == 2'b00 && TRACE_DATA == 16'h0000)
    else $error("flow word address or data wrong");
  AST_FLOW_WAIT: assert property ( // [RULE20]
    (capture && is_flow) |=> TRACE_WAIT == 4'h0)
    else $error("flow word shows wait count");

endmodule
`default_nettype wire

/* File: tb/bte_bus_model.sv */
// processor-bus side model: presents captured states and per-clock activity
`default_nettype none
module bte_bus_model
  import bte_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // captured state
  output var  logic        st_valid,
  output var  bte_class_t  cls,
  output var  logic        ad_valid,
  output var  logic [31:0] addr,
  output var  logic [15:0] data,
  output var  logic [3:0]  be,
  output var  logic [2:0]  bwords,
  output var  bte_kind_t   kind,
  // write, lock_n, cache, bad, emul, rom, guard, low target, source
  output var  logic [8:0]  flags,
  // per-clock activity
  output var  logic        wt,
  output var  logic        bstart,
  output var  logic        in_burst,
  output var  logic [3:0]  irq,
  output var  logic        hold
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet bus at time zero; lock idles high
  initial begin
    st_valid = 1'b0;
    cls      = BTE_FOREGROUND;
    ad_valid = 1'b0;
    addr     = 32'h0000_0000;
    data     = 16'h0000;
    be       = 4'h0;
    bwords   = 3'h0;
    kind     = BTE_K_INSTR;
    flags    = 9'h080;
    wt       = 1'b0;
    bstart   = 1'b0;
    in_burst = 1'b0;
    irq      = 4'h0;
    hold     = 1'b0;
  end

  // one captured state, offered for exactly one clock
  task automatic send(input bte_class_t c, input logic [31:0] a, input logic [15:0] d,
                      input logic [3:0] b, input logic [2:0] w, input bte_kind_t k,
                      input logic [8:0] f, input logic i);
    @(posedge mclk);
    st_valid <= 1'b1;
    cls      <= c;
    ad_valid <= 1'b1;
    addr     <= a;
    data     <= d;
    be       <= b;
    bwords   <= w;
    kind     <= k;
    flags    <= f;
    in_burst <= i;
    @(posedge mclk);
    // released lines show the inverse so a stale copy cannot pass
    st_valid <= 1'b0;
    ad_valid <= 1'b0;
    addr     <= ~a;
    data     <= ~d;
    in_burst <= 1'b0;
  endtask

  // activity levels held for n clocks, then dropped
  task automatic tick(input int n, input logic w, input logic [3:0] q, input logic h,
                      input logic s);
    @(posedge mclk);
    wt     <= w;
    irq    <= q;
    hold   <= h;
    bstart <= s;
    repeat (n) @(posedge mclk);
    wt     <= 1'b0;
    irq    <= 4'h0;
    hold   <= 1'b0;
    bstart <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/bte_encoder_tb_top.sv */
// testbench for the bus trace state encoder: register tasks and trace word checks
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module bte_encoder_tb_top
  import bte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, rst_n, st_valid, ad_valid, wt, bstart, in_burst, hold;
  bte_class_t  cls;
  bte_kind_t   kind;
  logic [31:0] addr, r_wdata, r_rdata, t_addr;
  logic [15:0] data, t_data;
  logic [3:0]  be, irq, t_wait;
  logic [2:0]  bwords, t_bpos;
  logic [8:0]  flags;
  logic [7:0]  r_addr, t_mm;
  logic [1:0]  t_size, t_bstlen;
  logic [30:0] t_st;
  logic        r_wr, r_rd, t_valid, fg_f, bg_f, fl_f;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  bte_bus_model i_bte_bus_model (
    .mclk(mclk), .st_valid(st_valid), .cls(cls), .ad_valid(ad_valid), .addr(addr),
    .data(data), .be(be), .bwords(bwords), .kind(kind), .flags(flags), .wt(wt),
    .bstart(bstart), .in_burst(in_burst), .irq(irq), .hold(hold));

  bte_encoder i_bte_encoder (
    .MCLK(mclk), .RESET_N(rst_n), .BUS_STATE_VALID(st_valid), .BUS_CLASS(cls),
    .BUS_AD_VALID(ad_valid), .BUS_ADDR(addr), .BUS_DATA(data), .BUS_BYTE_EN(be),
    .BUS_BURST_WORDS(bwords), .BUS_WRITE(flags[8]), .BUS_LOCK_N(flags[7]),
    .BUS_CACHEABLE(flags[6]), .BUS_BAD_ACCESS(flags[5]), .BUS_EMUL_MEM(flags[4]),
    .BUS_ROM(flags[3]), .BUS_GUARDED(flags[2]), .BUS_LOW_TARGET(flags[1]),
    .BUS_FLOW_KIND(kind), .BUS_FLOW_SOURCE(flags[0]), .BUS_WAIT(wt),
    .BUS_BURST_START(bstart), .BUS_IN_BURST(in_burst), .BUS_IRQ(irq), .BUS_HOLD(hold),
    .REG_ADDR(r_addr), .REG_WR_DATA(r_wdata), .REG_WR(r_wr), .REG_RD(r_rd),
    .REG_RD_DATA(r_rdata), .TRACE_VALID(t_valid), .TRACE_ADDR(t_addr),
    .TRACE_DATA(t_data), .TRACE_WAIT(t_wait), .TRACE_BURST_POS(t_bpos),
    .TRACE_SIZE(t_size), .TRACE_BSTLEN(t_bstlen), .TRACE_MEMMAP(t_mm),
    .TRACE_STATUS(t_st), .FOREGROUND_CYCLE_FLAG(fg_f),
    .BACKGROUND_CYCLE_FLAG(bg_f), .FLOW_MESSAGE_FLAG(fl_f));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand clocks
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // register write: one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    r_addr  <= a;
    r_wdata <= d;
    r_wr    <= 1'b1;
    @(posedge mclk);
    r_wr    <= 1'b0;
  endtask

  // register read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    r_addr <= a;
    r_rd   <= 1'b1;
    @(posedge mclk);
    r_rd   <= 1'b0;
    #1;
    `CHK("register read", e, r_rdata)
  endtask

  // one capture; the whole word must be out in the next cycle
  task automatic cap(input bte_class_t c, input logic [31:0] a, input logic [3:0] b,
                     input logic [2:0] w, input bte_kind_t k, input logic [8:0] f,
                     input logic i);
    i_bte_bus_model.send(c, a, ~a[15:0], b, w, k, f, i);
    #1;
    `CHK("trace valid", 1'b1, t_valid)
  endtask

  // main sequence
  initial begin
    logic [31:0] a;
    logic [30:0] s;
    rst_n   = 1'b0;
    r_addr  = 8'h00;
    r_wdata = 32'h0000_0000;
    r_wr    = 1'b0;
    r_rd    = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    `CHK("reset status", 31'h0000_4004, t_st)
    rd_reg(8'h00, 32'h0000_0001);
    $display("test reset done");
    // size and burst codes across all four lengths
    for (int i = 0; i < 4; i++) begin
      a = 32'h0000_1000 + 32'(i);
      cap(BTE_FOREGROUND, a, {i > 2, i > 1, i > 0, 1'b1}, 3'(i + 1), BTE_K_INSTR,
          9'h180, 1'b0);
      `CHK("size", 2'(i), t_size)
      `CHK("burst length", 2'(i), t_bstlen)
      `CHK("address", a, t_addr)
      `CHK("data", ~a[15:0], t_data)
      `CHK("memmap target ram", 8'h01, t_mm)
    end
    $display("test sizes done");
    // locked, cacheable, bad write after five wait states
    i_bte_bus_model.tick(5, 1'b1, 4'h0, 1'b0, 1'b0);
    cap(BTE_FOREGROUND, 32'h0000_2002, 4'h3, 3'h1, BTE_K_INSTR, 9'h162, 1'b0);
    `CHK("wait count", 4'h5, t_wait)
    `CHK("fg write status", 31'h0080_220A, t_st)
    `CHK("fg flags", 3'b100, {fg_f, bg_f, fl_f})
    `CHK("memmap low target", 8'h09, t_mm)
    // saturating count, guarded read
    i_bte_bus_model.tick(20, 1'b1, 4'h0, 1'b0, 1'b0);
    cap(BTE_FOREGROUND, 32'h0000_2100, 4'h1, 3'h1, BTE_K_INSTR, 9'h09C, 1'b0);
    `CHK("wait saturated", 4'hF, t_wait)
    `CHK("fg read status", 31'h0080_6204, t_st)
    `CHK("memmap guarded", 8'h11, t_mm)
    $display("test foreground done");
    // background reads with interrupt pins and hold seen in between
    i_bte_bus_model.tick(1, 1'b0, 4'hF, 1'b1, 1'b0);
    cap(BTE_BACKGROUND, 32'h0000_2200, 4'hF, 3'h1, BTE_K_INSTR, 9'h098, 1'b0);
    `CHK("bg status sticky", 31'h0100_64F4, t_st)
    `CHK("bg flags", 3'b010, {fg_f, bg_f, fl_f})
    `CHK("memmap emul rom", 8'h61, t_mm)
    cap(BTE_BACKGROUND, 32'h0000_2204, 4'hF, 3'h1, BTE_K_INSTR, 9'h098, 1'b0);
    `CHK("bg status cleared", 31'h0100_6004, t_st)
    $display("test background done");
    // every flow message kind, source and destination in turn
    for (int k = 0; k < 7; k++) begin
      a = 32'h2000_0003 + 32'(k << 8);
      cap(BTE_FLOW, a, 4'hF, 3'h1, bte_kind_t'(k), {8'h40, k[0]}, 1'b0);
      s = 31'h0200_6204 | (31'h1 << (15 + k)) | {8'h00, k[0], 22'h00_0000};
      `CHK("flow status", s, t_st)
      `CHK("flow address", a & 32'hFFFF_FFFC, t_addr)
      `CHK("flow data", 16'h0000, t_data)
      `CHK("flow flags", 3'b001, {fg_f, bg_f, fl_f})
    end
    $display("test flow done");
    // burst positions in the second variant
    wr_reg(8'h00, 32'h0000_0003);
    i_bte_bus_model.tick(1, 1'b0, 4'h0, 1'b0, 1'b1);
    for (int p = 0; p < 3; p++) begin
      cap(BTE_FOREGROUND, 32'h0000_3000, 4'hF, 3'h4, BTE_K_INSTR, 9'h180, 1'b1);
      `CHK("burst position", 3'(p), t_bpos)
    end
    cap(BTE_FOREGROUND, 32'h0000_3100, 4'hF, 3'h1, BTE_K_INSTR, 9'h180, 1'b0);
    `CHK("non-burst position", 3'h0, t_bpos)
    $display("test burst done");
    // disabled capture is dropped; unmapped read gives zero
    wr_reg(8'h00, 32'h0000_0000);
    i_bte_bus_model.send(BTE_FOREGROUND, 32'h0000_4000, 16'h1234, 4'hF, 3'h1, BTE_K_INSTR,
                         9'h180, 1'b0);
    #1;
    `CHK("dropped capture", 1'b0, t_valid)
    rd_reg(8'h00, 32'h0000_0000);
    rd_reg(8'h04, 32'h0000_0013);
    rd_reg(8'h10, 32'h0000_0000);
    $display("test registers done");
    test_done();
  end
endmodule
`default_nettype wire
